//--- ufn_pkg.sv
package ufn_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  UFN_FRAME_COUNT_OFS   = 8'h3c; // frame count register
  localparam logic [7:0]  UFN_PERIODIC_THR_OFS  = 8'h40; // periodic threshold register
  localparam logic [7:0]  UFN_FRAME_INTERVAL_OFS = 8'h34; // frame interval register
  localparam logic [7:0]  UFN_FRAME_REMAIN_OFS  = 8'h38; // frame remaining register
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          UFN_FIELD_W           = 14;      // counter field width
  localparam logic [13:0] UFN_COUNT_RST         = 14'h0000; // frame count after reset
  localparam logic [13:0] UFN_THR_RST           = 14'h0000; // threshold after reset
  localparam logic [13:0] UFN_INTERVAL_RST      = 14'h2edf; // nominal 11,999 bit times
  localparam logic [13:0] UFN_REMAIN_RST        = 14'h0000; // remaining after reset
  localparam int          UFN_SOF_FLAG_BIT      = 2;       // start-of-frame status bit
  // ----------------------------------------------------------------
  // timing: 12 Mbit/s bit time from a 20 MHz clock
  // ----------------------------------------------------------------
  localparam int          UFN_CLK_HZ            = 20000000; // controller clock
  localparam int          UFN_BIT_HZ            = 12000000; // full-speed bit rate
  // phase accumulator step per clock, in units of clock rate
  localparam logic [24:0] UFN_BIT_STEP          = 25'(UFN_BIT_HZ);
  localparam logic [24:0] UFN_BIT_MOD           = 25'(UFN_CLK_HZ);
  // ----------------------------------------------------------------
  // per-frame sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UFN_IDLE,
    UFN_SEND_SOF,
    UFN_WRITE_HCCA,
    UFN_RAISE_FLAG
  } ufn_seq_t;
endpackage

//--- ufn_bit_tick.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// bit-time tick generator: fractional divider, 12 ticks per 20 clocks
// ------------------------------------------------------------------
module ufn_bit_tick
  import ufn_pkg::*;
(
  input  wire logic clk_in,      // controller clock
  input  wire logic sys_rst_in,  // async reset, active high
  output logic      tick_out     // one-cycle pulse per bit time
);
  logic [24:0] phase;            // accumulator
  logic [25:0] next_phase;       // sum before wrap

  // sum of phase and step
  always_comb begin
    next_phase = {1'b0, phase} + {1'b0, UFN_BIT_STEP};
  end

  // wrap accumulator, pulse on wrap
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase    <= '0;
      tick_out <= 1'b0;
    end else if (next_phase >= {1'b0, UFN_BIT_MOD}) begin
      phase    <= 25'(next_phase - {1'b0, UFN_BIT_MOD});
      tick_out <= 1'b1;
    end else begin
      phase    <= next_phase[24:0];
      tick_out <= 1'b0;
    end
  end
endmodule

//--- ufn_frame_timer.sv
`timescale 1ns/1ps
module ufn_frame_timer
  import ufn_pkg::*;
#(
  parameter int FIELD_W = UFN_FIELD_W  // counter field width
)
(
  input  wire logic        clk_in,              // controller clock
  input  wire logic        sys_rst_in,          // async reset, active high
  input  wire logic        reg_wr_in,           // register write strobe
  input  wire logic        reg_rd_in,           // register read strobe
  input  wire logic [7:0]  reg_addr_in,         // register byte offset
  input  wire logic [31:0] reg_wdata_in,        // write data
  output logic      [31:0] reg_rdata_out,       // read data, registered
  input  wire logic        operational_state_in, // controller is operational
  input  wire logic        xfer_busy_in,        // control/bulk transaction in progress
  input  wire logic        hcca_ack_in,         // HCCA write accepted
  output logic             sof_out,             // SOF request pulse
  output logic             hcca_wr_out,         // HCCA write request, held until ack
  output logic      [31:0] hcca_data_out,       // frame count for HCCA
  output logic             start_of_frame_flag_out, // pulse setting status bit 2
  output logic             periodic_priority_out // periodic lists own the bus
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [FIELD_W-1:0] frame_count;       // frame number
  logic [FIELD_W-1:0] periodic_threshold; // periodic start point
  logic [FIELD_W-1:0] frame_interval;    // reload value
  logic               interval_toggle;   // interval toggle bit
  logic [FIELD_W-1:0] remaining_bit_times; // down counter
  logic               remain_toggle;     // copy of interval toggle
  logic               oper_q;            // operational state delayed
  logic               bit_tick;          // bit-time pulse
  logic               reload;            // counter reload this cycle
  logic               enter_oper;        // rising edge of operational
  logic               thr_hit;           // threshold reached
  logic               prio_pend;         // waiting for transaction end
  ufn_seq_t           seq;               // per-frame sequence

  // ----------------------------------------------------------------
  // bit-time tick
  // ----------------------------------------------------------------
  ufn_bit_tick u_tick (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_out   (bit_tick)
  );

  // frame boundary and entry detection
  assign enter_oper = operational_state_in & ~oper_q;
  assign reload     = operational_state_in & bit_tick & (remaining_bit_times == '0);
  assign thr_hit    = operational_state_in & bit_tick & (remaining_bit_times == periodic_threshold);

  // ----------------------------------------------------------------
  // operational edge tracker
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      oper_q <= 1'b0;
    end else begin
      oper_q <= operational_state_in;
    end
  end

  // ----------------------------------------------------------------
  // frame remaining down counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      remaining_bit_times <= UFN_REMAIN_RST;
      remain_toggle       <= 1'b0;
    end else if (enter_oper) begin
      // load interval on entry
      remaining_bit_times <= frame_interval;
    end else if (reload) begin
      // reload at zero, copy toggle
      remaining_bit_times <= frame_interval;
      remain_toggle       <= interval_toggle;
    end else if (operational_state_in && bit_tick) begin
      // one count per bit time
      remaining_bit_times <= remaining_bit_times - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // frame count
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frame_count <= UFN_COUNT_RST;
    end else if (reload || enter_oper) begin
      // natural wrap from all ones to zero
      frame_count <= frame_count + 1'b1;
    end else if (reg_wr_in && reg_addr_in == UFN_FRAME_COUNT_OFS) begin
      // software write, field only
      frame_count <= reg_wdata_in[FIELD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // software-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      periodic_threshold <= UFN_THR_RST;
      frame_interval     <= UFN_INTERVAL_RST;
      interval_toggle    <= 1'b0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        UFN_PERIODIC_THR_OFS: begin
          periodic_threshold <= reg_wdata_in[FIELD_W-1:0];
        end
        UFN_FRAME_INTERVAL_OFS: begin
          frame_interval  <= reg_wdata_in[FIELD_W-1:0];
          interval_toggle <= reg_wdata_in[31];
        end
        default: begin
          // other offsets belong elsewhere
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register read path, reserved bits read zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        UFN_FRAME_COUNT_OFS:    reg_rdata_out <= 32'(frame_count);
        UFN_PERIODIC_THR_OFS:   reg_rdata_out <= 32'(periodic_threshold);
        UFN_FRAME_INTERVAL_OFS: reg_rdata_out <= {interval_toggle, 17'h00000, frame_interval};
        UFN_FRAME_REMAIN_OFS:   reg_rdata_out <= {remain_toggle, 17'h00000, remaining_bit_times};
        default:                reg_rdata_out <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-frame sequence: SOF, HCCA write, flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seq                     <= UFN_IDLE;
      sof_out                 <= 1'b0;
      hcca_wr_out             <= 1'b0;
      hcca_data_out           <= '0;
      start_of_frame_flag_out <= 1'b0;
    end else begin
      sof_out                 <= 1'b0;
      start_of_frame_flag_out <= 1'b0;
      case (seq)
        UFN_IDLE: begin
          // wait for a boundary
          if (reload || enter_oper) begin
            seq     <= UFN_SEND_SOF;
            sof_out <= 1'b1;
          end
        end
        UFN_SEND_SOF: begin
          // count already incremented, publish it
          hcca_wr_out   <= 1'b1;
          hcca_data_out <= 32'(frame_count);
          seq           <= UFN_WRITE_HCCA;
        end
        UFN_WRITE_HCCA: begin
          // hold request until accepted
          if (hcca_ack_in) begin
            hcca_wr_out <= 1'b0;
            seq         <= UFN_RAISE_FLAG;
          end
        end
        UFN_RAISE_FLAG: begin
          start_of_frame_flag_out <= 1'b1;
          seq                     <= UFN_IDLE;
        end
        default: begin
          seq <= UFN_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // periodic priority: wait for busy transaction, hold to frame end
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prio_pend             <= 1'b0;
      periodic_priority_out <= 1'b0;
    end else if (reload || !operational_state_in) begin
      // frame over, control/bulk again
      prio_pend             <= 1'b0;
      periodic_priority_out <= 1'b0;
    end else if (thr_hit || prio_pend) begin
      if (xfer_busy_in) begin
        prio_pend <= 1'b1;
      end else begin
        prio_pend             <= 1'b0;
        periodic_priority_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_count_step: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reload || enter_oper) |=> frame_count == FIELD_W'($past(frame_count) + 1'b1))
    else $error("frame count did not step at boundary");
  a_count_wrap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reload && frame_count == '1) |=> frame_count == '0)
    else $error("frame count did not wrap");
  a_oper_bump: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(operational_state_in) |=> frame_count != $past(frame_count))
    else $error("no increment on entering operational");
  a_hcca_data: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sof_out |=> hcca_wr_out && hcca_data_out == 32'(frame_count))
    else $error("hcca write missing after sof");
  a_flag_after: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (hcca_wr_out && hcca_ack_in) |=> ##1 start_of_frame_flag_out)
    else $error("flag not raised after hcca write");
  a_thr_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (reg_wr_in && reg_addr_in == UFN_PERIODIC_THR_OFS)
      |=> periodic_threshold == $past(reg_wdata_in[FIELD_W-1:0]))
    else $error("threshold write lost");
  a_prio_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (prio_pend && xfer_busy_in && !reload) |=> !periodic_priority_out)
    else $error("priority taken during busy transaction");
  a_prio_grant: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (thr_hit && !xfer_busy_in && !reload) |=> periodic_priority_out)
    else $error("priority not granted at threshold");
  a_remain_dec: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (operational_state_in && oper_q && bit_tick && remaining_bit_times != '0)
      |=> remaining_bit_times == FIELD_W'($past(remaining_bit_times) - 1'b1))
    else $error("remaining counter did not decrement");
  c_frame: cover property (@(posedge clk_in) reload);
  c_flag: cover property (@(posedge clk_in) start_of_frame_flag_out);
  c_prio_wait: cover property (@(posedge clk_in) prio_pend ##1 periodic_priority_out);
  c_wrap: cover property (@(posedge clk_in) reload && frame_count == '1);
endmodule

//--- ufn_hcca_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// shared memory model: accepts frame-count writes
// ----------------------------------------------------------------
module ufn_hcca_model (
  input  wire logic        clk_in,     // controller clock
  input  wire logic        sys_rst_in, // async reset, active high
  input  wire logic        wr_in,      // write request from block
  input  wire logic [31:0] data_in,    // frame count word
  input  wire logic [3:0]  delay_in,   // wait cycles before accept
  output logic             ack_out,    // one-cycle accept pulse
  output logic      [31:0] mem_out     // last stored word
);
  logic [3:0] wait_q; // cycles spent on current request
  // accept after delay_in cycles, stalling the block meanwhile
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_out <= 1'b0;
      wait_q  <= 4'h0;
      mem_out <= 32'h0;
    end else if (wr_in && !ack_out) begin
      if (wait_q == delay_in) begin
        ack_out <= 1'b1;
        mem_out <= data_in;
        wait_q  <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else begin
      ack_out <= 1'b0; // pulse only
    end
  end
endmodule

//--- ufn_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s exp=%h got=%h", nm, ex, got); end end
module testbench;
  import ufn_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_in, sys_rst_in, reg_wr_in, reg_rd_in, op_q, busy_q;
  logic [7:0]  reg_addr_in;  // register offset
  logic [31:0] reg_wdata_in; // write data
  logic [31:0] rdata, hdata, mem, rd, rd2;
  logic        sof, hwr, ack, flag, prio;
  logic [3:0]  delay_q;      // memory stall length
  int          bad_count, n_compared, cycles;
  ufn_frame_timer ufn_frame_timer_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata),
    .operational_state_in(op_q), .xfer_busy_in(busy_q), .hcca_ack_in(ack), .sof_out(sof),
    .hcca_wr_out(hwr), .hcca_data_out(hdata), .start_of_frame_flag_out(flag), .periodic_priority_out(prio));
  ufn_hcca_model ufn_hcca_model_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_in(hwr),
    .data_in(hdata), .delay_in(delay_q), .ack_out(ack), .mem_out(mem));
  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // bus and wait helpers
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    #1 reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge clk_in);
    #1 reg_wr_in = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    #1 reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(posedge clk_in);
    #1 reg_rd_in = 1'b0;
    d = rdata;
  endtask
  // bounded wait for a frame start
  task automatic wait_sof();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while (sof !== 1'b1 && n < 200);
    `CHK("sof seen", 1'b1, sof)
  endtask
  // bounded wait for the status pulse; stored word shows it came after the write
  task automatic wait_flag(input logic [31:0] ex);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while (flag !== 1'b1 && n < 30);
    `CHK("flag", 1'b1, flag)
    `CHK("stored count", ex, mem)
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    reg_rd(UFN_FRAME_COUNT_OFS, rd);
    `CHK("count rst", 32'h0, rd)
    reg_rd(UFN_PERIODIC_THR_OFS, rd);
    `CHK("thr rst", 32'h0, rd)
    reg_rd(UFN_FRAME_INTERVAL_OFS, rd);
    `CHK("interval rst", 32'h00002edf, rd)
    reg_rd(8'h44, rd);
    `CHK("unmapped", 32'h0, rd)
  endtask
  task automatic t_regs();
    reg_wr(UFN_PERIODIC_THR_OFS, 32'h00003e67);
    reg_rd(UFN_PERIODIC_THR_OFS, rd);
    `CHK("thr typical", 32'h00003e67, rd)
    reg_wr(UFN_PERIODIC_THR_OFS, 32'h00003fff);
    reg_rd(UFN_PERIODIC_THR_OFS, rd);
    `CHK("thr max", 32'h00003fff, rd)
    reg_wr(UFN_FRAME_COUNT_OFS, 32'h00003ffe);
    reg_rd(UFN_FRAME_COUNT_OFS, rd);
    `CHK("count wr", 32'h00003ffe, rd)
  endtask
  // entry bump, wrap at next boundary, frame length, slow memory
  task automatic t_frames();
    realtime t0;
    int d;
    reg_wr(UFN_FRAME_INTERVAL_OFS, 32'h00000028);
    reg_wr(UFN_PERIODIC_THR_OFS, 32'h0000001e);
    #1 op_q = 1'b1;
    wait_sof();
    @(posedge clk_in);
    #1 `CHK("hcca wr", 1'b1, hwr)
    `CHK("entry count", 32'h00003fff, hdata)
    wait_flag(32'h00003fff);
    delay_q = 4'h6;
    wait_sof();
    // entry frame starts off the tick grid, so time reload to reload
    t0 = $realtime;
    reg_rd(UFN_FRAME_COUNT_OFS, rd);
    `CHK("count wrap", 32'h0, rd)
    wait_flag(32'h0);
    wait_sof();
    d = int'(($realtime - t0) / 50.0);
    `CHK("frame len", 1'b1, (d == 68 || d == 69))
  endtask
  // threshold match held off by a running transfer
  task automatic t_prio();
    logic seen;
    seen = 1'b0;
    wait_sof();
    busy_q = 1'b1;
    repeat (25) begin
      @(posedge clk_in);
      #1 seen = seen | prio;
    end
    `CHK("no prio while busy", 1'b0, seen)
    busy_q = 1'b0;
    repeat (3) @(posedge clk_in);
    #1 `CHK("prio", 1'b1, prio)
    wait_sof();
    repeat (2) @(posedge clk_in);
    #1 `CHK("prio cleared", 1'b0, prio)
    reg_rd(UFN_FRAME_REMAIN_OFS, rd);
    reg_rd(UFN_FRAME_REMAIN_OFS, rd2);
    `CHK("remaining below interval", 1'b1, rd[13:0] <= 14'h0028)
    `CHK("remaining counts down", 1'b1, rd2[13:0] < rd[13:0])
  endtask
  // mid-run reset clears a written threshold and the frame count
  task automatic t_rerun();
    reg_wr(UFN_PERIODIC_THR_OFS, 32'h00000123);
    sys_rst_in = 1'b1;
    op_q = 1'b0;
    busy_q = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    @(posedge clk_in);
    #1 `CHK("prio after rst", 1'b0, prio)
    `CHK("hcca wr after rst", 1'b0, hwr)
    reg_rd(UFN_PERIODIC_THR_OFS, rd);
    `CHK("thr rerun", 32'h0, rd)
    reg_rd(UFN_FRAME_COUNT_OFS, rd);
    `CHK("count rerun", 32'h0, rd)
  endtask
  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {reg_wr_in, reg_rd_in, op_q, busy_q} = 4'h0;
    reg_addr_in = 8'h0;
    reg_wdata_in = 32'h0;
    delay_q = 4'h0;
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    sys_rst_in = 1'b1;
    repeat (20) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    t_reset();
    t_regs();
    t_frames();
    t_prio();
    t_rerun();
    conclude();
  end
endmodule
